/* cst_crc32.sv */
// Byte-serial CRC-32 accumulator for the firmware image check.
// Assumes bytes come from a flash reader on the same clock.
`timescale 1ns/1ps
module cst_crc32 (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        clr,
	input  wire logic        en,
	input  wire logic [7:0]  data,
	output logic      [31:0] crc
);
	typedef struct packed {
		logic [31:0] acc;
	} cst_crc_t;

	cst_crc_t q;
	cst_crc_t d;

	function automatic logic [31:0] cst_crc_byte(input logic [31:0] c, input logic [7:0] b);
		logic [31:0] r;
		r = c ^ {24'h00_0000, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ cst_pkg::CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction : cst_crc_byte

	always_comb begin
		d = q;
		if (clr) begin
			d.acc = cst_pkg::CRC_INIT;
		end else if (en) begin
			d.acc = cst_crc_byte(q.acc, data);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			q.acc <= cst_pkg::CRC_INIT;
		end else begin
			q <= d;
		end
	end

	assign crc = q.acc ^ cst_pkg::CRC_XOROUT;
endmodule : cst_crc32

/* cst_peer.sv */
// Model of the image reader and the test engines that face the sequencer.
// Assumes the bench drives lat, fail_id and bad; all changes land on the falling edge.
`timescale 1ns/1ps
module cst_peer (
	input  wire logic        clk,
	input  wire logic        img_rd,
	input  wire logic        img_sel,
	input  wire logic        test_start,
	input  wire logic [7:0]  test_id,
	input  wire logic [3:0]  lat,
	input  wire logic [7:0]  fail_id,
	input  wire logic [1:0]  bad,
	output logic             img_valid,
	output logic             img_last,
	output logic      [7:0]  img_byte,
	output logic      [31:0] img_crc_ref,
	output logic             test_done,
	output logic             test_pass
);
	logic [7:0]  img [4] = '{8'h31, 8'h32, 8'h33, 8'h34};
	logic [31:0] good;
	logic [7:0]  id = 8'h00;
	logic        busy = 1'h0;
	int          idx = 0;
	int          cnt = 0;
	initial begin
		good = cst_pkg::CRC_INIT;
		foreach (img[i]) begin
			good ^= {24'h00_0000, img[i]};
			for (int k = 0; k < 8; k++) begin
				good = good[0] ? ((good >> 1) ^ cst_pkg::CRC_POLY) : (good >> 1);
			end
		end
		good ^= cst_pkg::CRC_XOROUT;
		{img_valid, img_last, test_done, test_pass} = 4'h0;
		img_byte = 8'h00;
	end
	// A bad image differs from its header by one bit
	assign img_crc_ref = good ^ {31'h0000_0000, bad[img_sel]};
	always @(negedge clk) begin
		test_done <= 1'h0;
		// Result line is not held between answers
		test_pass <= !test_pass;
		if (busy && cnt == 0) begin
			test_done <= 1'h1;
			test_pass <= (id !== fail_id);
			busy = 1'h0;
		end else if (busy) begin
			cnt--;
		end
		if (test_start === 1'h1) begin
			busy = 1'h1;
			cnt = lat;
			id = test_id;
		end
		if (img_rd === 1'h1 && idx < 4) begin
			img_valid <= 1'h1;
			img_byte <= img[idx];
			img_last <= (idx == 3);
			idx++;
		end else begin
			img_valid <= 1'h0;
			img_last <= 1'h0;
			img_byte <= ~img_byte;
			if (img_rd !== 1'h1) idx = 0;
		end
	end
endmodule : cst_peer

/* cst_pkg.sv */
// Shared constants and types of the crypto self-test sequencer.
// Assumes one 20 MHz clock and a synchronous active-low reset.
package cst_pkg;
	localparam int ID_W     = 8;
	localparam int KAT_NUM  = 12;
	localparam int COND_NUM = 2;
	localparam int DATA_W   = 8;

	// Reflected CRC-32 over the image bytes
	localparam logic [31:0] CRC_INIT   = 32'hFFFF_FFFF;
	localparam logic [31:0] CRC_POLY   = 32'hEDB8_8320;
	localparam logic [31:0] CRC_XOROUT = 32'hFFFF_FFFF;

	localparam logic IMG_PRIMARY  = 1'h0;
	localparam logic IMG_FALLBACK = 1'h1;

	localparam logic [1:0] LED_RED   = 2'h1;
	localparam logic [1:0] LED_AMBER = 2'h2;
	localparam logic [1:0] LED_GREEN = 2'h3;

	localparam logic [1:0] LOG_NONE      = 2'h0;
	localparam logic [1:0] LOG_COND_PASS = 2'h1;
	localparam logic [1:0] LOG_FWLOAD    = 2'h2;

	typedef enum logic [3:0] {
		S_OFF       = 4'b0000,
		S_CRC       = 4'b0001,
		S_CRC_FB    = 4'b0010,
		S_BOOT_FAIL = 4'b0011,
		S_KAT       = 4'b0100,
		S_COND      = 4'b0101,
		S_OPER      = 4'b0110,
		S_SOFT      = 4'b0111,
		S_FATAL     = 4'b1000
	} cst_state_t;
endpackage : cst_pkg

/* cst_seq.sv */
// Self-test and error-state sequencer of the cryptographic radio module.
// Assumes algorithm engines answer test_start with one test_done pulse later,
// and that the image reader streams bytes while img_rd is high.
// Operation
// - After power-up or reset all self-tests and then conditional tests run unaided.
// - The data output is blocked while tests run and while any error state holds.
// - No cryptographic use is enabled before every known-answer test has passed.
// - A failed known-answer test enters the fatal state, left only by a restart.
// - In the fatal state only the plain error page is served, naming the failed test.
// - Passing all known-answer tests moves the device towards its working state.
// - The mode indicator shows green, amber or red for approved, pending, non-approved.
// - A failed run-time conditional test other than firmware load is fatal.
// - A firmware-load failure enters a soft error state that reruns the known-answer tests.
// - A passing rerun logs the original cause and returns to operation.
// - The network interface stays up in the fatal state.
// - Passing power-up conditional tests ends boot; a failure is fatal.
// - Each passing conditional test is written to the log, run-time ones only in S_OPER without a same-cycle failure.
// - A power cycle or reset request restarts the whole self-test sequence.
`timescale 1ns/1ps
module cst_seq #(
	parameter int KAT_NUM  = cst_pkg::KAT_NUM,
	parameter int COND_NUM = cst_pkg::COND_NUM,
	parameter int DW       = cst_pkg::DATA_W
) (
	input  wire logic                    clk,
	input  wire logic                    rst_b,
	input  wire logic                    main_power_switch,
	input  wire logic                    reset_req,
	input  wire logic                    img_valid,
	input  wire logic                    img_last,
	input  wire logic [7:0]              img_byte,
	input  wire logic [31:0]             img_crc_ref,
	input  wire logic                    test_done,
	input  wire logic                    test_pass,
	input  wire logic                    cond_pass,
	input  wire logic                    cond_fail,
	input  wire logic [cst_pkg::ID_W-1:0] cond_id,
	input  wire logic                    fwload_fail,
	input  wire logic [cst_pkg::ID_W-1:0] fwload_code,
	input  wire logic                    cfg_approved,
	input  wire logic                    cfg_pending,
	input  wire logic [DW-1:0]           din,
	input  wire logic                    din_valid,
	output logic                         img_rd,
	output logic                         img_sel,
	output logic                         test_start,
	output logic      [cst_pkg::ID_W-1:0] test_id,
	output logic      [DW-1:0]           dout,
	output logic                         dout_valid,
	output logic                         crypto_en,
	output logic                         eth_en,
	output logic                         http_only,
	output logic                         fatal,
	output logic      [cst_pkg::ID_W-1:0] err_test_id,
	output logic      [1:0]              approved_mode_indicator,
	output logic                         log_valid,
	output logic      [1:0]              log_kind,
	output logic      [cst_pkg::ID_W-1:0] log_id
);
	localparam int IW = cst_pkg::ID_W;
	localparam logic [IW-1:0] KAT_LAST = IW'(KAT_NUM - 1);
	localparam logic [IW-1:0] ALL_LAST = IW'(KAT_NUM + COND_NUM - 1);

	typedef struct packed {
		cst_pkg::cst_state_t st;
		logic [IW-1:0]       tid;
		logic                busy;
		logic                start;
		logic                img_rd;
		logic                img_sel;
		logic                img_end;
		logic [IW-1:0]       cause;
		logic [IW-1:0]       err_id;
		logic                log_v;
		logic [1:0]          log_k;
		logic [IW-1:0]       log_id;
		logic                dout_en;
		logic                crypto_en;
		logic                http_only;
		logic                eth_en;
		logic                fatal;
		logic [1:0]          led;
		logic                dv;
		logic [DW-1:0]       dd;
	} cst_reg_t;

	cst_reg_t    q;
	cst_reg_t    d;
	logic        pwr_on;
	logic        restart;
	logic [31:0] crc_val;
	logic        test_run;

	cst_sync #(
		.W(1)
	) u_pwr_sync (
		.clk      (clk),
		.rst_b    (rst_b),
		.async_in (main_power_switch),
		.sync_out (pwr_on)
	);

	cst_crc32 u_crc (
		.clk   (clk),
		.rst_b (rst_b),
		.clr   (!q.img_rd),
		.en    (q.img_rd && img_valid),
		.data  (img_byte),
		.crc   (crc_val)
	);

	// Switch-off or a reset request both count as a power cycle
	assign restart  = reset_req || !pwr_on;
	assign test_run = q.st == cst_pkg::S_KAT || q.st == cst_pkg::S_COND
		|| q.st == cst_pkg::S_SOFT;

	always_comb begin
		d       = q;
		d.start = 1'b0;
		d.log_v = 1'b0;
		d.log_k = cst_pkg::LOG_NONE;
		case (q.st)
			cst_pkg::S_OFF: begin
				d.st      = cst_pkg::S_CRC;
				d.img_sel = cst_pkg::IMG_PRIMARY;
				d.img_rd  = 1'b1;
				d.img_end = 1'b0;
			end
			cst_pkg::S_CRC, cst_pkg::S_CRC_FB: begin
				if (q.img_rd && img_valid && img_last) begin
					d.img_rd  = 1'b0;
					d.img_end = 1'b1;
				end
				// Compare one cycle after the last byte, once the CRC has settled
				if (q.img_end) begin
					d.img_end = 1'b0;
					if (crc_val == img_crc_ref) begin
						d.st   = cst_pkg::S_KAT;
						d.tid  = '0;
						d.busy = 1'b0;
					end else if (q.st == cst_pkg::S_CRC) begin
						d.st      = cst_pkg::S_CRC_FB;
						d.img_sel = cst_pkg::IMG_FALLBACK;
						d.img_rd  = 1'b1;
					end else begin
						d.st = cst_pkg::S_BOOT_FAIL;
					end
				end
			end
			cst_pkg::S_KAT, cst_pkg::S_COND, cst_pkg::S_SOFT: begin
				if (!q.busy) begin
					d.start = 1'b1;
					d.busy  = 1'b1;
				end else if (test_done) begin
					d.busy = 1'b0;
					d.tid  = q.tid + 1'b1;
					if (!test_pass) begin
						d.st     = cst_pkg::S_FATAL;
						d.err_id = q.tid;
					end else if (q.st == cst_pkg::S_KAT) begin
						if (q.tid == KAT_LAST) begin
							d.st = cst_pkg::S_COND;
						end
					end else if (q.st == cst_pkg::S_COND) begin
						d.log_v  = 1'b1;
						d.log_k  = cst_pkg::LOG_COND_PASS;
						d.log_id = q.tid;
						if (q.tid == ALL_LAST) begin
							d.st = cst_pkg::S_OPER;
						end
					end else if (q.tid == KAT_LAST) begin
						d.st     = cst_pkg::S_OPER;
						d.log_v  = 1'b1;
						d.log_k  = cst_pkg::LOG_FWLOAD;
						d.log_id = q.cause;
					end
				end
			end
			cst_pkg::S_OPER: begin
				// A hard failure outranks a firmware-load failure in the same cycle
				if (cond_fail) begin
					d.st     = cst_pkg::S_FATAL;
					d.err_id = cond_id;
				end else if (fwload_fail) begin
					d.st    = cst_pkg::S_SOFT;
					d.cause = fwload_code;
					d.tid   = '0;
					d.busy  = 1'b0;
				end else if (cond_pass) begin
					d.log_v  = 1'b1;
					d.log_k  = cst_pkg::LOG_COND_PASS;
					d.log_id = cond_id;
				end
			end
			cst_pkg::S_BOOT_FAIL, cst_pkg::S_FATAL: begin
				d.st = q.st;
			end
			default: begin
				d.st = cst_pkg::S_OFF;
			end
		endcase
		if (restart) begin
			d.st      = cst_pkg::S_OFF;
			d.busy    = 1'b0;
			d.start   = 1'b0;
			d.img_rd  = 1'b0;
			d.img_end = 1'b0;
		end
		// Outputs follow the next state so they leave flip-flops aligned with it
		d.dout_en   = d.st == cst_pkg::S_OPER;
		d.crypto_en = d.st == cst_pkg::S_COND || d.st == cst_pkg::S_OPER;
		d.fatal     = d.st == cst_pkg::S_FATAL;
		d.http_only = d.st == cst_pkg::S_FATAL;
		// Soft error shuts every interface; fatal keeps the link for the error page
		d.eth_en = d.st == cst_pkg::S_OPER || d.st == cst_pkg::S_FATAL;
		if (d.st != cst_pkg::S_OPER) begin
			d.led = cst_pkg::LED_RED;
		end else if (cfg_approved) begin
			d.led = cst_pkg::LED_GREEN;
		end else if (cfg_pending) begin
			d.led = cst_pkg::LED_AMBER;
		end else begin
			d.led = cst_pkg::LED_RED;
		end
		d.dv = din_valid && d.dout_en;
		d.dd = d.dv ? din : '0;
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			q     <= '0;
			q.led <= cst_pkg::LED_RED;
		end else begin
			q <= d;
		end
	end

	assign img_rd                  = q.img_rd;
	assign img_sel                 = q.img_sel;
	assign test_start              = q.start;
	assign test_id                 = q.tid;
	assign dout                    = q.dd;
	assign dout_valid              = q.dv;
	assign crypto_en               = q.crypto_en;
	assign eth_en                  = q.eth_en;
	assign http_only               = q.http_only;
	assign fatal                   = q.fatal;
	assign err_test_id             = q.err_id;
	assign approved_mode_indicator = q.led;
	assign log_valid               = q.log_v;
	assign log_kind                = q.log_k;
	assign log_id                  = q.log_id;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	AST_BOOT_AUTO: assert property (q.st == cst_pkg::S_OFF && !restart
		|=> q.st == cst_pkg::S_CRC && img_rd)
		else $error("boot did not start by itself");
	AST_DOUT_BLOCK: assert property (dout_valid
		|-> q.st == cst_pkg::S_OPER && !fatal && $past(din_valid))
		else $error("data left while tests ran or in error");
	// The soft rerun also ends in operation once its answer tests pass
	AST_CRYPTO_AFTER_KAT: assert property ($rose(crypto_en)
		|-> $past((q.st == cst_pkg::S_KAT || q.st == cst_pkg::S_SOFT) && q.tid == KAT_LAST
		&& test_done && test_pass))
		else $error("crypto enabled before all answer tests passed");
	AST_TEST_FAIL_FATAL: assert property (test_run && q.busy && test_done
		&& !test_pass && !restart |=> fatal && http_only && err_test_id == $past(q.tid))
		else $error("failed test did not reach fatal state");
	AST_FATAL_HOLDS: assert property (fatal && !restart |=> fatal ##0 eth_en)
		else $error("fatal state left without restart");
	AST_COND_FAIL: assert property (q.st == cst_pkg::S_OPER && cond_fail
		&& !restart |=> fatal && err_test_id == $past(cond_id))
		else $error("run-time test failure not fatal");
	AST_FWLOAD_SOFT: assert property (q.st == cst_pkg::S_OPER && fwload_fail
		&& !cond_fail && !restart |=> q.st == cst_pkg::S_SOFT && !eth_en
		##1 (test_start || $past(restart)))
		else $error("firmware-load failure did not rerun self-test");
	AST_SOFT_LOG: assert property (q.st == cst_pkg::S_SOFT && q.busy && test_done
		&& test_pass && q.tid == KAT_LAST && !restart
		|=> log_valid && log_kind == cst_pkg::LOG_FWLOAD && log_id == q.cause && eth_en)
		else $error("soft recovery did not log its cause");
	AST_LOG_PASS: assert property (q.st == cst_pkg::S_COND && q.busy && test_done
		&& test_pass && !restart |=> log_valid && log_kind == cst_pkg::LOG_COND_PASS)
		else $error("passing conditional test not logged");
	AST_LED_GREEN: assert property (approved_mode_indicator == cst_pkg::LED_GREEN
		|-> q.st == cst_pkg::S_OPER && $past(cfg_approved))
		else $error("green shown outside approved operation");
	AST_BOOT_FAIL_RED: assert property (q.st == cst_pkg::S_BOOT_FAIL && !restart
		|=> q.st == cst_pkg::S_BOOT_FAIL && approved_mode_indicator == cst_pkg::LED_RED
		&& !crypto_en && !eth_en)
		else $error("boot failure left or not red");
	AST_BOOT_DONE: assert property (q.st == cst_pkg::S_COND && q.busy && test_done
		&& test_pass && q.tid == ALL_LAST && !restart |=> q.st == cst_pkg::S_OPER
		&& crypto_en && eth_en && !fatal)
		else $error("power-up did not finish after last conditional test");
	AST_HTTP_FATAL: assert property (http_only |-> fatal && eth_en && !dout_valid)
		else $error("plain error page outside the fatal state");
	AST_DOUT_DATA: assert property (dout_valid |-> dout == $past(din))
		else $error("output data does not follow the input");

	COV_REACH_OPER: cover property (q.st == cst_pkg::S_COND ##1 q.st == cst_pkg::S_OPER);
	COV_FATAL: cover property (test_run ##1 fatal);
	COV_SOFT_BACK: cover property (q.st == cst_pkg::S_SOFT ##1 q.st == cst_pkg::S_OPER);
	COV_FALLBACK: cover property (q.st == cst_pkg::S_CRC_FB ##1 q.st == cst_pkg::S_KAT);
endmodule : cst_seq

/* cst_sync.sv */
// Two-stage synchroniser for levels arriving from pins.
// Assumes the input is a slow level; pulses shorter than one clock may be lost.
`timescale 1ns/1ps
module cst_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} cst_sync_t;

	cst_sync_t q;
	cst_sync_t d;

	always_comb begin
		d.meta   = async_in;
		d.stable = q.meta;
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign sync_out = q.stable;
endmodule : cst_sync

/* tb.sv */
// Self-checking bench for the self-test sequencer with the engine and image model.
// Assumes 20 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ps
module tb;
	logic        clk = 1'h0;
	logic        rst_b, main_power_switch, reset_req, cond_pass, cond_fail, fwload_fail;
	logic        cfg_approved, cfg_pending, din_valid, img_valid, img_last, test_done, test_pass;
	logic        img_rd, img_sel, test_start, dout_valid, crypto_en, eth_en, http_only, fatal;
	logic        log_valid;
	logic [7:0]  cond_id, fwload_code, din, img_byte, test_id, dout, err_test_id, log_id, fail_id;
	logic [7:0]  lid;
	logic [31:0] img_crc_ref;
	logic [1:0]  approved_mode_indicator, log_kind, bad, lkind;
	logic [3:0]  lat;
	int          failures = 0;
	int          n_tests = 0;
	int          n_start = 0;

	always #25 clk = ~clk;

	cst_seq dut (.clk(clk), .rst_b(rst_b), .main_power_switch(main_power_switch),
		.reset_req(reset_req), .img_valid(img_valid), .img_last(img_last), .img_byte(img_byte),
		.img_crc_ref(img_crc_ref), .test_done(test_done), .test_pass(test_pass),
		.cond_pass(cond_pass), .cond_fail(cond_fail), .cond_id(cond_id),
		.fwload_fail(fwload_fail), .fwload_code(fwload_code), .cfg_approved(cfg_approved),
		.cfg_pending(cfg_pending), .din(din), .din_valid(din_valid), .img_rd(img_rd),
		.img_sel(img_sel), .test_start(test_start), .test_id(test_id), .dout(dout),
		.dout_valid(dout_valid), .crypto_en(crypto_en), .eth_en(eth_en),
		.http_only(http_only), .fatal(fatal), .err_test_id(err_test_id),
		.approved_mode_indicator(approved_mode_indicator), .log_valid(log_valid),
		.log_kind(log_kind), .log_id(log_id));

	cst_peer peer (.clk(clk), .img_rd(img_rd), .img_sel(img_sel), .test_start(test_start),
		.test_id(test_id), .lat(lat), .fail_id(fail_id), .bad(bad), .img_valid(img_valid),
		.img_last(img_last), .img_byte(img_byte), .img_crc_ref(img_crc_ref),
		.test_done(test_done), .test_pass(test_pass));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task end_of_test();
		$display("failures=%0d n_tests=%0d", failures, n_tests);
		if (failures == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : end_of_test

	// Monitor: start order, gating of the data path, red while the image is read
	always @(negedge clk) begin
		if (rst_b === 1'h1) begin
			if (test_start === 1'h1) begin
				if (test_id < 8'h0C) chk(crypto_en, 1'h0);
				chk(test_id, n_start);
				n_start++;
			end
			if (!(eth_en === 1'h1 && fatal === 1'h0)) chk(dout_valid, 1'h0);
			else if (dout_valid === 1'h1) chk(dout, din);
			if (img_rd === 1'h1) chk(approved_mode_indicator, cst_pkg::LED_RED);
			if (log_valid === 1'h1) begin
				lkind = log_kind;
				lid = log_id;
			end
			din <= din + 8'h01;
		end
	end

	task wait_st(input logic want_fatal);
		int i;
		for (i = 0; i < 3000 && !(eth_en === 1'h1 && fatal === want_fatal); i++) @(negedge clk);
		if (i >= 3000) begin
			failures++;
			$display("ERROR %0t: state not reached", $time);
			end_of_test();
		end
	endtask : wait_st

	task restart();
		@(negedge clk);
		reset_req = 1'h1;
		n_start = 0;
		@(negedge clk);
		reset_req = 1'h0;
		chk(crypto_en, 1'h0);
		chk(approved_mode_indicator, cst_pkg::LED_RED);
	endtask : restart

	task pulse(input int k, input logic [7:0] id);
		@(negedge clk);
		cond_id = id;
		fwload_code = id;
		{cond_pass, cond_fail, fwload_fail} = {k == 0, k == 1, k == 2};
		@(negedge clk);
		{cond_pass, cond_fail, fwload_fail} = 3'h0;
	endtask : pulse

	task automatic t_boot();
		logic [1:0] cfgs [3] = '{2'h2, 2'h1, 2'h0};
		logic [1:0] leds [3] = '{cst_pkg::LED_GREEN, cst_pkg::LED_AMBER, cst_pkg::LED_RED};
		wait_st(1'h0);
		chk(n_start, cst_pkg::KAT_NUM + cst_pkg::COND_NUM);
		chk(crypto_en, 1'h1);
		chk(img_sel, cst_pkg::IMG_PRIMARY);
		for (int i = 0; i < 3; i++) begin
			{cfg_approved, cfg_pending} = cfgs[i];
			repeat (3) @(negedge clk);
			chk(approved_mode_indicator, leds[i]);
		end
		chk({lkind, lid}, {cst_pkg::LOG_COND_PASS, 8'h0D});
		$display("test boot done");
	endtask : t_boot

	task t_kat_fail();
		fail_id = 8'h05;
		lat = 4'h3;
		restart();
		wait_st(1'h1);
		chk(err_test_id, 8'h05);
		chk(n_start, 6);
		chk(http_only, 1'h1);
		chk(crypto_en, 1'h0);
		pulse(0, 8'h11);
		repeat (20) @(negedge clk);
		chk(fatal, 1'h1);
		chk(eth_en, 1'h1);
		fail_id = 8'hFF;
		$display("test kat_fail done");
	endtask : t_kat_fail

	task t_cond_fail();
		fail_id = 8'h0D;
		restart();
		wait_st(1'h1);
		chk(err_test_id, 8'h0D);
		chk(n_start, 14);
		fail_id = 8'hFF;
		$display("test cond_fail done");
	endtask : t_cond_fail

	task t_runtime();
		lat = 4'h0;
		restart();
		wait_st(1'h0);
		pulse(0, 8'h21);
		chk({log_valid, log_kind, log_id}, {1'h1, cst_pkg::LOG_COND_PASS, 8'h21});
		n_start = 0;
		pulse(2, 8'h5A);
		chk({eth_en, crypto_en, fatal}, 3'h0);
		wait_st(1'h0);
		repeat (2) @(negedge clk);
		chk(n_start, cst_pkg::KAT_NUM);
		chk({lkind, lid}, {cst_pkg::LOG_FWLOAD, 8'h5A});
		fail_id = 8'h03;
		n_start = 0;
		pulse(2, 8'h66);
		wait_st(1'h1);
		chk(err_test_id, 8'h03);
		fail_id = 8'hFF;
		restart();
		wait_st(1'h0);
		pulse(1, 8'h44);
		chk({fatal, http_only, err_test_id}, {2'h3, 8'h44});
		$display("test runtime done");
	endtask : t_runtime

	task t_power();
		main_power_switch = 1'h0;
		repeat (4) @(negedge clk);
		chk({eth_en, crypto_en, approved_mode_indicator}, {2'h0, cst_pkg::LED_RED});
		n_start = 0;
		main_power_switch = 1'h1;
		wait_st(1'h0);
		chk(n_start, 14);
		chk(fatal, 1'h0);
		$display("test power done");
	endtask : t_power

	task t_image();
		bad = 2'h1;
		restart();
		wait_st(1'h0);
		chk(img_sel, cst_pkg::IMG_FALLBACK);
		bad = 2'h3;
		restart();
		repeat (300) @(negedge clk);
		chk({img_rd, eth_en, crypto_en, approved_mode_indicator}, {3'h0, cst_pkg::LED_RED});
		chk(n_start, 0);
		$display("test image done");
	endtask : t_image

	initial begin
		{rst_b, reset_req, cond_pass, cond_fail, fwload_fail, cfg_pending} = 6'h00;
		{main_power_switch, cfg_approved, din_valid} = 3'h7;
		{cond_id, fwload_code, din} = 24'h00_0000;
		{lkind, lid} = 10'h000;
		lat = 4'h0;
		fail_id = 8'hFF;
		bad = 2'h0;
		repeat (16) @(negedge clk);
		rst_b = 1'h1;
		t_boot();
		t_kat_fail();
		t_cond_fail();
		t_runtime();
		t_power();
		t_image();
		end_of_test();
	end
endmodule : tb
